// *** gpl_pkg.sv ***
// Functional notes
// [R1] Level-1 entry with a defined value in [3:0] is a granules entry.
// [R2] A granules entry holds sixteen 4-bit values, one per granule.
// [R3] Granule index PA[15:12], PA[17:14] or PA[19:16] for 4KB, 16KB, 64KB.
// [R4] Protection value is entry bits 4*i+3 down to 4*i.
// [R5] 0000 none; 1000, 1001, 1010, 1011 one space; 1111 all; rest reserved.
// [R6] Level-1 entry with [3:0] equal 0001 is a contiguous entry.
// [R7] Contiguous entry: size [9:8], protection value [7:4], [63:10] zero.
// [R8] Contiguity size 01 is 2MB, 10 is 32MB, 11 is 512MB; 00 reserved.
// [R9] Contiguous regions are naturally aligned to their size.
// [R10] Contiguous information may be cached for at most its indicated range.
// [R11] With 4KB granules, sixteen equal values may be cached as a 64KB block.
// [R12] Cached contiguous data stays until maintenance covers its full range.
// [R13] Disagreeing contiguous values may permit or fault as one value says.
// [R14] Consistent contiguous ranges are checked exactly against their value.
// [R15] Every table entry read is one 64-bit single-copy atomic access.
// [R16] PA splits into size check, level-0, level-1 and granule indices.
// [R17] Granule shift is 12, 14 or 16 for size codes 00, 10, 01.
// [R18] Protected size within level-0 entry size: one level-0 entry at zero.
// [R19] Level-1 index is PA[s-1:16], PA[s-1:18] or PA[s-1:20] by granule size.
// [R20] Software sizes each level-1 table from entry size and granule size.
// [R21] Walk faults stay ordered after accesses ordered before their request.
// [R22] Level-0 size codes 0000, 0100, 0110, 1001 give s of 30, 34, 36, 39.
// [R23] Unknown, reserved-encoded or nonzero reserved-bit entries are invalid.
// [R24] Software aligns each level-1 table to its own size.
// [R25] A value not permitting the access's space yields a protection fault.
package gpl_pkg;
  localparam int unsigned PA_W = 52;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_BASE_LO = 12'h004;
  localparam logic [11:0] OFS_BASE_HI = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_MAINT = 12'h010;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_PGS_LSB = 1;
  localparam int unsigned CTRL_L0SZ_LSB = 4;
  localparam int unsigned CTRL_PPS_LSB = 8;
  localparam logic [3:0] GPV_NONE = 4'h0;
  localparam logic [1:0] GPV_ONE_HI = 2'h2;
  localparam logic [3:0] GPV_ALL = 4'hF;
  localparam logic [3:0] DESC_CONTIG = 4'h1;
  localparam logic [3:0] DESC_BLOCK = 4'h1;
  localparam logic [3:0] DESC_TABLE = 4'h3;
  localparam logic [1:0] PGS_4K = 2'h0;
  localparam logic [1:0] PGS_16K = 2'h2;
  localparam logic [1:0] PGS_64K = 2'h1;
  localparam logic [5:0] P_4K = 6'h0C;
  localparam logic [5:0] P_16K = 6'h0E;
  localparam logic [5:0] P_64K = 6'h10;
  localparam logic [3:0] L0SZ_1G = 4'h0;
  localparam logic [3:0] L0SZ_16G = 4'h4;
  localparam logic [3:0] L0SZ_64G = 4'h6;
  localparam logic [3:0] L0SZ_512G = 4'h9;
  localparam logic [5:0] S_1G = 6'h1E;
  localparam logic [5:0] S_16G = 6'h22;
  localparam logic [5:0] S_64G = 6'h24;
  localparam logic [5:0] S_512G = 6'h27;
  localparam logic [5:0] CONTIG_2M = 6'h15;
  localparam logic [5:0] CONTIG_32M = 6'h19;
  localparam logic [5:0] CONTIG_512M = 6'h1D;
  localparam logic [5:0] BLOCK_64K = 6'h10;
  localparam logic [5:0] DESC_BYTES_SHIFT = 6'h03;
  localparam logic [5:0] TABLE_ADDR_LSB = 6'h0C;

  typedef enum logic [1:0] {
    PAS_SECURE, PAS_NONSEC, PAS_ROOT, PAS_REALM
  } gpl_pas_t;
  typedef enum logic [2:0] {
    FLT_NONE, FLT_PROT, FLT_WALK, FLT_ADDR_SIZE, FLT_CONFIG, FLT_BUS
  } gpl_fault_t;

  typedef struct packed {
    logic [PA_W-1:0] pa;
    gpl_pas_t pas;
  } gpl_req_t;

  typedef struct packed {
    logic [3:0] gpv;
    gpl_fault_t fault;
  } gpl_rsp_t;

  typedef struct packed {
    logic [2:0] protected_pa_size;
    logic [3:0] l0sz;
    logic [1:0] physical_granule_size;
    logic enable;
  } gpl_ctrl_t;
endpackage

// *** gpl_lookup.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpl_lookup
  import gpl_pkg::*;
#(
  parameter int unsigned PaWidth = 52
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reqValid,
  output logic reqReady,
  input wire gpl_req_t req,
  output logic rspValid,
  input wire logic rspReady,
  output gpl_rsp_t rsp,
  output logic memReqValid,
  input wire logic memReqReady,
  output logic [PA_W-1:0] memReqAddr,
  input wire logic memRspValid,
  input wire logic [63:0] memRspData,
  input wire logic memRspErr
);

  // The walker only works on the full physical address width.
  if (PaWidth != PA_W)
  begin : gWidthCheck
    $error("PaWidth must equal the package address width.");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_L0_REQ, ST_L0_WAIT, ST_L1_REQ, ST_L1_WAIT, ST_RESP
  } gpl_state_t;

  gpl_state_t state_q;
  gpl_ctrl_t ctrl_q;
  gpl_req_t req_q;
  gpl_rsp_t rsp_q;
  logic [PA_W-1:0] base_q;
  logic [PA_W-1:0] l1Base_q;
  logic [PA_W-1:0] memAddr_q;
  logic memValid_q;
  logic faultSeen_q;
  logic [2:0] lastFault_q;
  logic cValid_q;
  logic [PA_W-1:0] cBase_q;
  logic [PA_W-1:0] cMask_q;
  logic [3:0] cGpv_q;
  logic [5:0] pShift;
  logic [5:0] sShift;
  logic [5:0] tBits;
  logic cfgOk;
  logic [PA_W-1:0] sMask;
  logic [PA_W-1:0] l0Offset;
  logic [PA_W-1:0] l1Offset;
  logic [3:0] gIdx;
  logic [3:0] gGpv;
  logic [15:0] nibOk;
  logic [15:0] nibSame;
  logic [3:0] cDescGpv;
  logic [5:0] cShift;
  logic gpvDefined;
  logic cHit;
  logic addrTooBig;
  logic apbWr;
  logic apbAccess;
  logic mapped;

  // Decode the granule shift, level-0 entry size and protected width.
  always_comb
  begin
    pShift = P_4K;
    sShift = S_1G;
    tBits = 6'd32;
    cfgOk = 1'b1;
    unique case (ctrl_q.physical_granule_size)
      PGS_4K: pShift = P_4K; // [R17]
      PGS_16K: pShift = P_16K; // [R17]
      PGS_64K: pShift = P_64K; // [R17]
      default: cfgOk = 1'b0;
    endcase
    unique case (ctrl_q.l0sz)
      L0SZ_1G: sShift = S_1G; // [R22]
      L0SZ_16G: sShift = S_16G; // [R22]
      L0SZ_64G: sShift = S_64G; // [R22]
      L0SZ_512G: sShift = S_512G; // [R22]
      default: cfgOk = 1'b0;
    endcase
    unique case (ctrl_q.protected_pa_size)
      3'd0: tBits = 6'd32;
      3'd1: tBits = 6'd36;
      3'd2: tBits = 6'd40;
      3'd3: tBits = 6'd42;
      3'd4: tBits = 6'd44;
      3'd5: tBits = 6'd48;
      3'd6: tBits = 6'd52;
      default: cfgOk = 1'b0;
    endcase
  end

  // Physical address slicing for both table levels.
  always_comb
  begin
    sMask = ({PA_W{1'b1}} << sShift) ^ {PA_W{1'b1}};
    // Bits above t must be zero when t is below the full width.
    addrTooBig = (tBits < 6'd52) && ((req_q.pa >> tBits) != '0); // [R16]
    if (tBits <= sShift)
    begin
      l0Offset = '0; // [R18]
    end
    else
    begin
      l0Offset = (req_q.pa >> sShift) << DESC_BYTES_SHIFT; // [R16]
    end
    // Level-1 index is PA[s-1:p+4], scaled to 8-byte entries.
    l1Offset = ((req_q.pa & sMask) >> (pShift + 6'd4))
      << DESC_BYTES_SHIFT; // [R19]
    gIdx = 4'((req_q.pa >> pShift) & 52'hF); // [R3]
  end

  // A defined protection value for a four-bit field.
  function automatic logic gpvValid(input logic [3:0] v);
    gpvValid = (v == GPV_NONE) || (v == GPV_ALL)
      || (v[3:2] == GPV_ONE_HI); // [R5]
  endfunction

  // Check each of the sixteen fields of a granules entry.
  for (genvar g = 0; g < 16; g++)
  begin : gNib
    assign nibOk[g] = gpvValid(memRspData[4*g+3:4*g]); // [R2]
    assign nibSame[g] = memRspData[4*g+3:4*g] == memRspData[3:0]; // [R11]
  end

  // Select the indexed value and decode the contiguous fields.
  always_comb
  begin
    gGpv = 4'((memRspData >> {gIdx, 2'b00}) & 64'hF); // [R4]
    cDescGpv = memRspData[7:4]; // [R7]
    gpvDefined = gpvValid(memRspData[3:0]);
    cShift = CONTIG_2M;
    unique case (memRspData[9:8])
      2'h1: cShift = CONTIG_2M; // [R8]
      2'h2: cShift = CONTIG_32M; // [R8]
      2'h3: cShift = CONTIG_512M; // [R8]
      default: cShift = CONTIG_2M;
    endcase
  end

  // Cached region lookup over a naturally aligned base.
  assign cHit = cValid_q && ((req_q.pa & ~cMask_q) == cBase_q); // [R9]

  // Permission check of a value against the access's address space.
  function automatic gpl_fault_t permit(input logic [3:0] v,
    input gpl_pas_t s);
    if (v == GPV_ALL || v == {GPV_ONE_HI, s})
    begin
      permit = FLT_NONE;
    end
    else
    begin
      permit = FLT_PROT; // [R25]
    end
  endfunction

  assign apbAccess = psel && penable && ce;
  assign apbWr = apbAccess && pwrite;
  assign mapped = paddr == OFS_CTRL || paddr == OFS_BASE_LO
    || paddr == OFS_BASE_HI || paddr == OFS_STATUS || paddr == OFS_MAINT;
  assign pready = ce;
  assign pslverr = psel && penable && !mapped;

  // Register read mux; unmapped offsets read zero.
  always_comb
  begin
    prdata = '0;
    if (paddr == OFS_CTRL)
    begin
      prdata[CTRL_EN_BIT] = ctrl_q.enable;
      prdata[CTRL_PGS_LSB +: 2] = ctrl_q.physical_granule_size;
      prdata[CTRL_L0SZ_LSB +: 4] = ctrl_q.l0sz;
      prdata[CTRL_PPS_LSB +: 3] = ctrl_q.protected_pa_size;
    end
    else if (paddr == OFS_BASE_LO)
    begin
      prdata = {base_q[31:12], 12'h000};
    end
    else if (paddr == OFS_BASE_HI)
    begin
      prdata = 32'(base_q[PA_W-1:32]);
    end
    else if (paddr == OFS_STATUS)
    begin
      prdata = {19'h00000, cValid_q, cGpv_q, rsp_q.gpv, lastFault_q,
        faultSeen_q};
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q.enable <= CTRL_RESET[CTRL_EN_BIT];
      ctrl_q.physical_granule_size <= CTRL_RESET[CTRL_PGS_LSB +: 2];
      ctrl_q.l0sz <= CTRL_RESET[CTRL_L0SZ_LSB +: 4];
      ctrl_q.protected_pa_size <= CTRL_RESET[CTRL_PPS_LSB +: 3];
      base_q <= '0;
    end
    else if (apbWr && paddr == OFS_CTRL)
    begin
      // Fields sit at their register positions, not in struct order.
      ctrl_q.enable <= pwdata[CTRL_EN_BIT];
      ctrl_q.physical_granule_size <= pwdata[CTRL_PGS_LSB +: 2];
      ctrl_q.l0sz <= pwdata[CTRL_L0SZ_LSB +: 4];
      ctrl_q.protected_pa_size <= pwdata[CTRL_PPS_LSB +: 3];
    end
    else if (apbWr && paddr == OFS_BASE_LO)
    begin
      base_q[31:12] <= pwdata[31:12];
    end
    else if (apbWr && paddr == OFS_BASE_HI)
    begin
      base_q[PA_W-1:32] <= pwdata[PA_W-33:0];
    end
  end

  // Sticky fault flag; a new fault wins over a write-one clear.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      faultSeen_q <= 1'b0;
      lastFault_q <= 3'h0;
    end
    else if (ce)
    begin
      if (state_q == ST_RESP && rspReady && rsp_q.fault != FLT_NONE)
      begin
        faultSeen_q <= 1'b1;
        lastFault_q <= rsp_q.fault;
      end
      else if (apbWr && paddr == OFS_STATUS && pwdata[0])
      begin
        faultSeen_q <= 1'b0;
      end
    end
  end

  // One-entry region cache. Maintenance clears the whole entry, so any
  // range write covers the full contiguity; a control write also clears
  // it. Clear beats a same-cycle fill since that walk may be stale.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cValid_q <= 1'b0;
      cBase_q <= '0;
      cMask_q <= '0;
      cGpv_q <= GPV_NONE;
    end
    else if (ce)
    begin
      if (apbWr && (paddr == OFS_MAINT || paddr == OFS_CTRL))
      begin
        cValid_q <= 1'b0; // [R12]
      end
      else if (state_q == ST_L1_WAIT && memRspValid && !memRspErr)
      begin
        if (memRspData[3:0] == DESC_CONTIG && memRspData[63:10] == '0
          && memRspData[9:8] != 2'h0 && gpvValid(cDescGpv))
        begin
          cValid_q <= 1'b1; // [R10]
          cMask_q <= ({PA_W{1'b1}} << cShift) ^ {PA_W{1'b1}};
          cBase_q <= req_q.pa & ({PA_W{1'b1}} << cShift); // [R9]
          cGpv_q <= cDescGpv; // [R14]
        end
        else if (pShift == P_4K && &nibOk && &nibSame)
        begin
          cValid_q <= 1'b1; // [R11]
          cMask_q <= ({PA_W{1'b1}} << BLOCK_64K) ^ {PA_W{1'b1}};
          cBase_q <= req_q.pa & ({PA_W{1'b1}} << BLOCK_64K);
          cGpv_q <= memRspData[3:0];
        end
      end
    end
  end

  assign reqReady = ce && state_q == ST_IDLE;
  assign rspValid = state_q == ST_RESP;
  assign rsp = rsp_q;
  assign memReqValid = memValid_q;
  assign memReqAddr = memAddr_q;

  // Walk sequencer. One request is in flight and answers leave in
  // request order, so a walk fault never passes an earlier access.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= ST_IDLE;
      req_q <= '0;
      rsp_q <= '0;
      l1Base_q <= '0;
      memAddr_q <= '0;
      memValid_q <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (reqValid)
          begin
            req_q <= req;
            state_q <= ST_L0_REQ; // [R21]
          end
        end
        ST_L0_REQ:
        begin
          if (!ctrl_q.enable)
          begin
            rsp_q <= '{gpv: GPV_ALL, fault: FLT_NONE};
            state_q <= ST_RESP;
          end
          else if (!cfgOk)
          begin
            rsp_q <= '{gpv: GPV_NONE, fault: FLT_CONFIG};
            state_q <= ST_RESP;
          end
          else if (addrTooBig)
          begin
            rsp_q <= '{gpv: GPV_NONE, fault: FLT_ADDR_SIZE}; // [R16]
            state_q <= ST_RESP;
          end
          else if (cHit)
          begin
            rsp_q <= '{gpv: cGpv_q, fault: permit(cGpv_q, req_q.pas)};
            state_q <= ST_RESP; // [R13]
          end
          else
          begin
            // Aligned 8-byte read, one beat.
            memAddr_q <= (base_q + l0Offset) & ~52'h7; // [R15]
            memValid_q <= 1'b1;
            state_q <= ST_L0_WAIT;
          end
        end
        ST_L0_WAIT:
        begin
          if (memReqReady)
          begin
            memValid_q <= 1'b0;
          end
          if (memRspValid)
          begin
            state_q <= ST_RESP;
            if (memRspErr)
            begin
              rsp_q <= '{gpv: GPV_NONE, fault: FLT_BUS};
            end
            else if (memRspData[3:0] == DESC_TABLE
              && memRspData[63:52] == '0 && memRspData[11:4] == '0)
            begin
              l1Base_q <= {memRspData[PA_W-1:12], 12'h000};
              state_q <= ST_L1_REQ;
            end
            else if (memRspData[3:0] == DESC_BLOCK
              && memRspData[63:8] == '0 && gpvValid(memRspData[7:4]))
            begin
              rsp_q <= '{gpv: memRspData[7:4],
                fault: permit(memRspData[7:4], req_q.pas)};
            end
            else
            begin
              rsp_q <= '{gpv: GPV_NONE, fault: FLT_WALK}; // [R23]
            end
          end
        end
        ST_L1_REQ:
        begin
          memAddr_q <= (l1Base_q + l1Offset) & ~52'h7; // [R15]
          memValid_q <= 1'b1;
          state_q <= ST_L1_WAIT;
        end
        ST_L1_WAIT:
        begin
          if (memReqReady)
          begin
            memValid_q <= 1'b0;
          end
          if (memRspValid)
          begin
            state_q <= ST_RESP;
            if (memRspErr)
            begin
              rsp_q <= '{gpv: GPV_NONE, fault: FLT_BUS};
            end
            else if (memRspData[3:0] == DESC_CONTIG) // [R6]
            begin
              if (memRspData[63:10] == '0 && memRspData[9:8] != 2'h0
                && gpvValid(cDescGpv)) // [R7]
              begin
                rsp_q <= '{gpv: cDescGpv,
                  fault: permit(cDescGpv, req_q.pas)};
              end
              else
              begin
                rsp_q <= '{gpv: GPV_NONE, fault: FLT_WALK}; // [R23]
              end
            end
            else if (gpvDefined) // [R1]
            begin
              if (&nibOk)
              begin
                rsp_q <= '{gpv: gGpv, fault: permit(gGpv, req_q.pas)};
              end
              else
              begin
                rsp_q <= '{gpv: GPV_NONE, fault: FLT_WALK}; // [R23]
              end
            end
            else
            begin
              rsp_q <= '{gpv: GPV_NONE, fault: FLT_WALK}; // [R23]
            end
          end
        end
        ST_RESP:
        begin
          if (rspReady)
          begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** gpl_lookup_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpl_lookup_props
  import gpl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire gpl_req_t req,
  input wire logic rspValid,
  input wire logic rspReady,
  input wire gpl_rsp_t rsp,
  input wire logic memReqValid,
  input wire logic memReqReady,
  input wire logic [PA_W-1:0] memReqAddr,
  input wire logic memRspValid,
  input wire logic memRspErr
);
  gpl_pas_t pasQ;
  logic busyQ;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  function automatic logic permits(input logic [3:0] g, input gpl_pas_t s);
    return g == GPV_ALL || g == {GPV_ONE_HI, s};
  endfunction

  // The verdict is judged against the space of the check in flight.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pasQ <= PAS_SECURE;
    else if (reqValid && reqReady)
      pasQ <= req.pas;
  end

  // Busy from acceptance until the answer is taken, so stray reads show.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      busyQ <= 1'b0;
    else if (reqValid && reqReady)
      busyQ <= 1'b1;
    else if (rspValid && rspReady)
      busyQ <= 1'b0;
  end

  atomic_read_a: assert property (
    memReqValid |-> memReqAddr[2:0] == 3'h0)
    else $error("table read not on an 8-byte boundary");
  read_hold_a: assert property (
    memReqValid && !memReqReady |=> memReqValid && $stable(memReqAddr))
    else $error("table read dropped or moved before acceptance");
  rsp_hold_a: assert property (
    rspValid && !rspReady |=> rspValid && $stable(rsp))
    else $error("answer changed before it was taken");
  verdict_a: assert property (
    rspValid && rsp.fault inside {FLT_NONE, FLT_PROT}
    |-> (rsp.fault == FLT_NONE) == permits(rsp.gpv, pasQ))
    else $error("permission verdict disagrees with protection value");
  gpv_legal_a: assert property (
    rspValid && rsp.fault == FLT_NONE
    |-> rsp.gpv inside {4'h8, 4'h9, 4'hA, 4'hB, 4'hF})
    else $error("access granted with a non-granting value");
  walk_owned_a: assert property (
    memReqValid |-> busyQ)
    else $error("table read without a check in flight");
  single_flight_a: assert property (
    busyQ |-> !reqReady)
    else $error("second check accepted while one is in flight");
  bus_err_a: assert property (
    memRspValid && memRspErr |=> rspValid && rsp.fault == FLT_BUS)
    else $error("memory error not reported next cycle");
  next_step_a: assert property (
    memRspValid && !memRspErr |-> ##[1:2] (memReqValid || rspValid))
    else $error("walk stalled after a table entry arrived");

  cover property (rspValid && rspReady && rsp.fault == FLT_NONE);
  cover property (rspValid && rspReady && rsp.fault == FLT_PROT);
  cover property (rspValid && rspReady && rsp.fault == FLT_WALK);
  cover property (rspValid && rspReady && rsp.fault == FLT_BUS);
endmodule

bind gpl_lookup gpl_lookup_props i_gpl_lookup_props (
  .clk(clk), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady),
  .req(req), .rspValid(rspValid), .rspReady(rspReady), .rsp(rsp),
  .memReqValid(memReqValid), .memReqReady(memReqReady),
  .memReqAddr(memReqAddr), .memRspValid(memRspValid),
  .memRspErr(memRspErr));
`default_nettype wire

// *** gpl_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpl_mem_model
  import gpl_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] lag,
  input wire logic memReqValid,
  input wire logic [PA_W-1:0] memReqAddr,
  output logic memReqReady,
  output logic memRspValid,
  output logic [63:0] memRspData,
  output logic memRspErr
);
  logic [63:0] mem [logic [PA_W-1:0]];

  // Each read is answered whole in one beat after a lag the bench picks;
  // an address never written answers with an error, and idle data is junk.
  initial
  begin
    memReqReady = 1'b0;
    memRspValid = 1'b0;
    memRspErr = 1'b0;
    memRspData = 64'h0;
    forever
    begin
      @(posedge clk);
      if (memReqValid === 1'b1)
      begin
        repeat (lag) @(posedge clk);
        memReqReady <= 1'b1;
        memRspValid <= 1'b1;
        memRspErr <= !mem.exists(memReqAddr);
        memRspData <= mem.exists(memReqAddr) ? mem[memReqAddr] : ~memRspData;
        @(posedge clk);
        memReqReady <= 1'b0;
        memRspValid <= 1'b0;
        memRspData <= ~memRspData;
      end
    end
  end
endmodule
`default_nettype wire

// *** gpl_lookup_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module gpl_lookup_test
  import gpl_pkg::*;
;
  localparam logic [51:0] BASE = 52'h0_0000_0001_0000;
  localparam logic [51:0] L1B = 52'h0_0000_0400_0000;
  localparam logic [1:0] PGSV [3] = '{PGS_4K, PGS_16K, PGS_64K};
  localparam logic [3:0] L0V [4] = '{L0SZ_1G, L0SZ_16G, L0SZ_64G, L0SZ_512G};
  localparam logic [3:0] GVV [6] = '{4'h0, 4'h8, 4'h9, 4'hA, 4'hB, 4'hF};
  localparam logic [63:0] BAD [4] = '{64'h81, 64'h581,
    64'hFFFF_FFFF_FFFF_FF2F, 64'h2};
  localparam int TW [7] = '{32, 36, 40, 42, 44, 48, 52};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, reqReady, rspValid, memReqValid, memReqReady;
  logic reqValid = 1'b0, rspReady = 1'b0;
  gpl_req_t req = '0;
  gpl_rsp_t rsp, want;
  logic [PA_W-1:0] memReqAddr;
  logic memRspValid, memRspErr;
  logic [63:0] memRspData;
  logic [1:0] lag = 2'h0;
  logic [31:0] seed = 32'h0000_15E7;
  int errors = 0, n_compared = 0, cyc = 0, sv, pv, tv;
  gpl_rsp_t expQ [$];

  gpl_lookup #(.PaWidth(52)) i_gpl_lookup (.clk(clk), .rstn(rstn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reqValid(reqValid), .reqReady(reqReady), .req(req),
    .rspValid(rspValid), .rspReady(rspReady), .rsp(rsp),
    .memReqValid(memReqValid), .memReqReady(memReqReady),
    .memReqAddr(memReqAddr), .memRspValid(memRspValid),
    .memRspData(memRspData), .memRspErr(memRspErr));
  gpl_mem_model i_gpl_mem_model (.clk(clk), .lag(lag),
    .memReqValid(memReqValid), .memReqAddr(memReqAddr),
    .memReqReady(memReqReady), .memRspValid(memRspValid),
    .memRspData(memRspData), .memRspErr(memRspErr));

  initial
  begin
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic ok(input logic [3:0] g, input gpl_pas_t s);
    return g == GPV_ALL || g == {GPV_ONE_HI, s};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // Writing control also drops any cached result.
  task automatic setup(input logic [1:0] g, input logic [3:0] l, input int t);
    wr(OFS_CTRL, {21'h0, 3'(t), l, 1'b0, g, 1'b1});
    pv = g == PGS_4K ? P_4K : g == PGS_16K ? P_16K : P_64K;
    sv = l == L0SZ_1G ? S_1G : l == L0SZ_16G ? S_16G :
      l == L0SZ_64G ? S_64G : S_512G;
    tv = TW[t];
  endtask

  // Lays out both table levels for pa, then issues one check.
  task automatic look(input logic [51:0] pa, input gpl_pas_t pas,
    input logic [63:0] ent, input logic [3:0] gv, input gpl_fault_t f,
    input logic mnt);
    logic [51:0] l0a, l1a;
    l0a = tv > sv ? BASE + ((pa >> sv) << 3) : BASE;
    l1a = L1B + (((pa & ((52'h1 << sv) - 52'h1)) >> (pv + 4))
      << 3);
    i_gpl_mem_model.mem[l0a] = {12'h0, L1B[51:12], 8'h0, DESC_TABLE};
    i_gpl_mem_model.mem[l1a] = ent;
    if (mnt)
      wr(OFS_MAINT, 32'h1);
    lag <= 2'(xs());
    @(posedge clk);
    reqValid <= 1'b1;
    req <= '{pa: pa, pas: pas};
    do
      @(posedge clk);
    while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    expQ.push_back('{gpv: gv, fault: f});
    while (expQ.size() != 0)
      @(posedge clk);
  endtask

  // Each answer is matched against the oldest expectation.
  always @(posedge clk)
    if (rspValid === 1'b1 && rspReady === 1'b1)
    begin
      if (expQ.size() == 0)
        check(32'h1, 32'h0);
      else
      begin
        want = expQ.pop_front();
        if (want.fault inside {FLT_NONE, FLT_PROT})
          check(32'(rsp), 32'(want));
        else
          check(32'(rsp.fault), 32'(want.fault));
      end
    end

  // The requester stalls answers at random; the ceiling cuts a hang short.
  always @(posedge clk)
  begin
    rspReady <= 2'(xs()) != 2'h0;
    cyc++;
    if (cyc == 40000)
    begin
      errors++;
      conclude();
    end
  end

  initial
  begin
    logic [31:0] q;
    logic e;
    logic [51:0] pa;
    logic [63:0] ent;
    logic [3:0] gv;
    gpl_pas_t pas;
    gpl_fault_t f;
    int i, sh;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0, q, e);
    check(q, CTRL_RESET);
    apb(1'b0, 12'h014, 32'h0, q, e);
    check({q[30:0], e}, 32'h1);
    wr(OFS_BASE_LO, BASE[31:0]);
    wr(OFS_BASE_HI, 32'h0);
    look(52'h0, PAS_ROOT, 64'h0, GPV_ALL, FLT_NONE, 1'b1);
    $display("test registers done");
    for (int g = 0; g < 3; g++)
      for (int l = 0; l < 4; l++)
        for (int k = 0; k < 6; k++)
        begin
          setup(PGSV[g], L0V[l], k[0] ? 6 : 0);
          for (int n = 0; n < 16; n++)
            ent[4*n +: 4] = GVV[xs() % 6];
          pa = tv > 32 ? {12'h0, 8'(xs()), xs()} : {20'h0, xs()};
          pas = gpl_pas_t'(2'(xs()));
          i = int'((pa >> pv) & 52'hF);
          gv = ent[4*i +: 4];
          f = ok(gv, pas) ? FLT_NONE : FLT_PROT;
          look(pa, pas, ent, gv, f, 1'b1);
        end
    $display("test granules done");
    setup(PGS_4K, L0SZ_512G, 0);
    for (int c = 0; c < 4; c++)
    begin
      sh = c == 0 ? 16 : 17 + 4 * c;
      gv = GVV[1 + xs() % 5];
      pas = gpl_pas_t'(2'(xs()));
      ent = c == 0 ? {16{gv}} : {54'h0, 2'(c), gv, DESC_CONTIG};
      pa = {20'h0, 1'b0, 31'(xs())};
      f = ok(gv, pas) ? FLT_NONE : FLT_PROT;
      look(pa, pas, ent, gv, f, 1'b1);
      pa = (pa >> sh) << sh;
      look(pa, pas, ent, gv, f, 1'b0);
      look(pa + (52'h1 << sh), pas, 64'h0, GPV_NONE, FLT_PROT, 1'b0);
    end
    $display("test contiguous done");
    for (int j = 0; j < 4; j++)
      look({20'h0, xs()}, PAS_REALM, BAD[j], 4'h0, FLT_WALK, 1'b1);
    look(52'h1_0000_0000, PAS_SECURE, 64'h0, 4'h0, FLT_ADDR_SIZE,
      1'b1);
    wr(OFS_BASE_LO, 32'h0002_0000);
    look(52'h0, PAS_SECURE, 64'h0, 4'h0, FLT_BUS, 1'b1);
    $display("test faults done");
    conclude();
  end
endmodule
`default_nettype wire
